// ==== logic/iotcm_consts.svh ====
`ifndef IOTCM_CONSTS_SVH
`define IOTCM_CONSTS_SVH
// ==========================================================
// Capacity and timing
`define IOTCM_BUF_WORDS 8192
`define IOTCM_MAX_PTS   16
`define IOTCM_TICK_MS   10
`define IOTCM_CLK_KHZ   250000
// ==========================================================
// Register word indexes
`define IOTCM_A_CTRL    5'h00
`define IOTCM_A_STATUS  5'h01
`define IOTCM_A_PERIOD  5'h02
`define IOTCM_A_NPTS    5'h03
`define IOTCM_A_PTYPE   5'h04
`define IOTCM_A_TCFG    5'h05
`define IOTCM_A_TTIME   5'h06
`define IOTCM_A_WPTR    5'h07
`define IOTCM_A_BADDR   5'h08
`define IOTCM_A_BDATA   5'h09
`define IOTCM_A_TVAL    5'h10
// ==========================================================
// Control fields
`define IOTCM_CTRL_AND   3
`define IOTCM_CTRL_START 4
`define IOTCM_CTRL_STOP  5
// ==========================================================
// Reset values
`define IOTCM_PERIOD_RST 16'h0001
`define IOTCM_NPTS_RST   5'h01
`endif

// ==== logic/iotcm_pkg.sv ====
package iotcm_pkg;
  typedef enum logic [2:0] {
    M_CONT_CHART  = 3'h0,
    M_TRIG_CHART  = 3'h1,
    M_CONT_TRACE  = 3'h2,
    M_TRIG_TRACE  = 3'h3,
    M_CMD_TRACE   = 3'h4,
    M_SNAPSHOT    = 3'h5
  } iotcm_mode_t;
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_RUN  = 3'b010,
    ST_POST = 3'b100
  } iotcm_run_t;
  typedef enum logic [2:0] {
    CS_STOP             = 3'h0,
    CS_RUN              = 3'h1,
    CS_HALT_STATE       = 3'h2,
    CS_ERROR            = 3'h3,
    CS_DEBUG_RUN        = 3'h4,
    CS_DEBUG_HALT_STATE = 3'h5
  } iotcm_cpu_st_t;
  typedef enum logic [1:0] {
    EX_FREE  = 2'h0,
    EX_NSCAN = 2'h1,
    EX_STEP  = 2'h2
  } iotcm_exec_t;
  typedef enum logic [1:0] {
    PT_BIT   = 2'h0,
    PT_WORD  = 2'h1,
    PT_DWORD = 2'h2
  } iotcm_pt_t;
  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } iotcm_bus_t;
  typedef struct packed {
    iotcm_cpu_st_t state;
    iotcm_exec_t   exec;
    logic          ochg_halt;
    logic          scan_start;
  } iotcm_cpu_t;
endpackage : iotcm_pkg

// ==== logic/iotcm_trig_match.sv ====
`timescale 1ns/1ps
`default_nettype none
module iotcm_trig_match #(
  parameter int NPT = 16
) (
  input  wire logic [NPT-1:0][15:0] trig_io,
  input  wire logic [NPT-1:0][15:0] trig_val,
  input  wire logic [NPT-1:0]       trig_en,
  input  wire logic [NPT-1:0]       trig_word,
  input  wire logic                 bit_only,
  input  wire logic                 and_sel,
  output logic                      match
);
  logic [NPT-1:0] hit;
  logic           all_hit;
  logic           any_hit;

  if (NPT < 1 || NPT > 16) begin : g_chk
    $error("iotcm_trig_match: NPT must be 1..16");
  end

  for (genvar i = 0; i < NPT; i++) begin : g_hit
    // Time-chart triggers look at the bit value only
    assign hit[i] = (trig_word[i] && !bit_only) ? (trig_io[i] == trig_val[i])
                                                : (trig_io[i][0] == trig_val[i][0]);
  end

  assign all_hit = &(hit | ~trig_en);
  assign any_hit = |(hit & trig_en);
  // No enabled point never matches, so an empty setup cannot fire
  assign match   = (|trig_en) && (and_sel ? all_hit : any_hit);
endmodule : iotcm_trig_match
`default_nettype wire

// ==== logic/iotcm_top.sv ====
`include "iotcm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module iotcm_top #(
  parameter int TICK_CYC  = `IOTCM_TICK_MS * `IOTCM_CLK_KHZ,
  parameter int NPT       = `IOTCM_MAX_PTS,
  parameter int BUF_WORDS = `IOTCM_BUF_WORDS
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire iotcm_pkg::iotcm_bus_t bus,
  output logic [31:0]               bus_rdata,
  input  wire iotcm_pkg::iotcm_cpu_t cpu,
  input  wire logic                 trace_arm_instruction,
  input  wire logic                 trace_sample_instruction,
  input  wire logic                 trace_disarm_instruction,
  output logic [3:0]                pt_sel,
  input  wire logic [31:0]          pt_data,
  input  wire logic [NPT-1:0][15:0] trig_io,
  output logic                      trigger_match_flag,
  output logic                      sampling_active_flag
);
  localparam int AW   = $clog2(BUF_WORDS);
  localparam int HALF = BUF_WORDS / 2;
  localparam logic [AW:0]   BUF_LIM   = (AW + 1)'(BUF_WORDS);
  localparam logic [AW-1:0] HALF_LIM  = AW'(HALF);
  localparam logic [31:0]   TICK_LAST = 32'(TICK_CYC - 1);

  if (TICK_CYC < 2 || NPT < 1 || NPT > 16 || BUF_WORDS < 64 ||
      (1 << AW) != BUF_WORDS) begin : g_chk
    $error("iotcm_top: unsupported parameter values");
  end

  // ==========================================================
  // Helpers
  function automatic iotcm_pkg::iotcm_pt_t pt_type(input logic [31:0] pt,
                                                   input logic [3:0]  i);
    return iotcm_pkg::iotcm_pt_t'(pt[{i, 1'b0} +: 2]);
  endfunction : pt_type

  function automatic logic [5:0] words_per_set(input logic [31:0] pt,
                                               input logic [4:0]  n,
                                               input logic        bo);
    logic [5:0] s;
    s = 6'h00;
    for (int i = 0; i < 16; i++) begin
      if (5'(i) < n) begin
        s = s + ((!bo && pt_type(pt, 4'(i)) == iotcm_pkg::PT_DWORD) ? 6'h02 : 6'h01);
      end
    end
    return s;
  endfunction : words_per_set

  // ==========================================================
  // State
  iotcm_pkg::iotcm_run_t  st_reg;
  iotcm_pkg::iotcm_run_t  st_next;
  iotcm_pkg::iotcm_mode_t mode_reg;
  logic                   and_reg;
  logic [15:0]            period_reg;
  logic [4:0]             npts_reg;
  logic [31:0]            ptype_reg;
  logic [15:0]            ten_reg;
  logic [15:0]            tword_reg;
  logic [NPT-1:0][15:0]   tval_reg;
  logic [AW-1:0]          wptr_reg;
  logic [AW-1:0]          baddr_reg;
  logic [AW-1:0]          post_reg;
  logic                   busy_reg;
  logic [3:0]             idx_reg;
  logic                   hi_reg;
  logic                   trig_reg;
  logic                   ovf_reg;
  logic                   done_reg;
  logic [31:0]            tick_cnt_reg;
  logic [31:0]            time_reg;
  logic [31:0]            ttime_reg;
  logic [15:0]            per_cnt_reg;
  logic [15:0]            scan_tk_reg;
  logic [1:0]             run_tk_reg;
  logic [31:0]            rdata_reg;
  logic [31:0]            rd_mux;
  logic [15:0]            mem [BUF_WORDS];

  // ==========================================================
  // Decode
  wire a_ctrl   = bus.addr == `IOTCM_A_CTRL;
  wire a_bdata  = bus.addr == `IOTCM_A_BDATA;
  wire a_tval   = bus.addr[4] && (32'(bus.addr[3:0]) < NPT);
  wire start    = bus.wr && a_ctrl && bus.wdata[`IOTCM_CTRL_START];
  wire stop_cmd = bus.wr && a_ctrl && bus.wdata[`IOTCM_CTRL_STOP];

  wire m_cont = mode_reg == iotcm_pkg::M_CONT_CHART || mode_reg == iotcm_pkg::M_CONT_TRACE;
  wire m_trig = mode_reg == iotcm_pkg::M_TRIG_CHART || mode_reg == iotcm_pkg::M_TRIG_TRACE;
  wire m_per  = m_cont || m_trig;
  wire m_cmd  = mode_reg == iotcm_pkg::M_CMD_TRACE;
  wire m_snap = mode_reg == iotcm_pkg::M_SNAPSHOT;
  // Chart modes sample and trigger on bit values only
  wire bit_only = mode_reg == iotcm_pkg::M_CONT_CHART ||
                  mode_reg == iotcm_pkg::M_TRIG_CHART;

  wire active = st_reg != iotcm_pkg::ST_OFF;
  wire tick   = tick_cnt_reg == TICK_LAST;
  wire per_fire = tick && (per_cnt_reg + 16'h0001 >= period_reg);

  // ==========================================================
  // CPU state gating
  wire cpu_ok = !cpu.ochg_halt &&
                (cpu.state == iotcm_pkg::CS_RUN ||
                 cpu.state == iotcm_pkg::CS_DEBUG_RUN);
  wire lim    = cpu.exec != iotcm_pkg::EX_FREE;
  wire nscan  = cpu.exec == iotcm_pkg::EX_NSCAN;
  wire per_ok  = !lim || (nscan && scan_tk_reg > period_reg);
  wire snap_ok = !lim || (nscan && run_tk_reg == 2'h2);

  logic tmatch;
  iotcm_trig_match #(.NPT(NPT)) u_match (
    .trig_io   (trig_io),
    .trig_val  (tval_reg),
    .trig_en   (ten_reg[NPT-1:0]),
    .trig_word (tword_reg[NPT-1:0]),
    .bit_only  (bit_only),
    .and_sel   (and_reg),
    .match     (tmatch)
  );

  // ==========================================================
  // Sample requests
  wire per_req  = active && m_per && per_fire && cpu_ok && per_ok;
  // Step mode reaches here only through the instruction pulse
  wire cmd_req  = active && m_cmd && trace_sample_instruction && cpu_ok;
  wire snap_req = active && m_snap && tick && cpu_ok && snap_ok && tmatch;
  wire req      = per_req || cmd_req || snap_req;
  wire post_full = st_reg == iotcm_pkg::ST_POST && post_reg >= HALF_LIM;
  // In continuous modes, a set still being written when the next one is due is an overrun
  wire ovf_hit  = req && busy_reg && m_cont;
  wire go       = req && !busy_reg && !post_full;
  wire trig_hit = per_req && m_trig && tmatch && st_reg == iotcm_pkg::ST_RUN;
  wire trig_set = trig_hit || snap_req || (cmd_req && !trig_reg);

  // ==========================================================
  // Store engine
  wire [5:0] wps = words_per_set(ptype_reg, npts_reg, bit_only);
  wire iotcm_pkg::iotcm_pt_t cur_t = pt_type(ptype_reg, idx_reg);
  wire is_dw = !bit_only && cur_t == iotcm_pkg::PT_DWORD;
  wire is_w  = !bit_only && cur_t == iotcm_pkg::PT_WORD;
  wire [15:0] wr_word = is_dw ? (hi_reg ? pt_data[31:16] : pt_data[15:0]) :
                        is_w  ? pt_data[15:0] : {15'h0000, pt_data[0]};
  wire we       = busy_reg && !post_full;
  wire last_wd  = (5'(idx_reg) == npts_reg - 5'h01) && (!is_dw || hi_reg);
  // Restart at zero when a whole set no longer fits
  wire set_fits = ({1'b0, wptr_reg} + (AW + 1)'(wps)) <= BUF_LIM;

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[wptr_reg] <= wr_word;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
      idx_reg  <= 4'h0;
      hi_reg   <= 1'b0;
    end else if (go) begin
      busy_reg <= 1'b1;
      idx_reg  <= 4'h0;
      hi_reg   <= 1'b0;
    end else if (busy_reg) begin
      busy_reg <= !(last_wd || post_full);
      hi_reg   <= is_dw && !hi_reg;
      idx_reg  <= (is_dw && !hi_reg) ? idx_reg : idx_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wptr_reg <= '0;
      post_reg <= '0;
    end else if (start) begin
      wptr_reg <= '0;
      post_reg <= '0;
    end else begin
      if (go && !set_fits) begin
        wptr_reg <= '0;
      end else if (we) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (we && st_reg == iotcm_pkg::ST_POST) begin
        post_reg <= post_reg + 1'b1;
      end
    end
  end

  // ==========================================================
  // Trace state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      iotcm_pkg::ST_OFF: begin
        if (start || (trace_arm_instruction && m_cmd)) begin
          st_next = iotcm_pkg::ST_RUN;
        end
      end
      iotcm_pkg::ST_RUN: begin
        if (stop_cmd || ovf_hit || snap_req ||
            (trace_disarm_instruction && m_cmd)) begin
          st_next = iotcm_pkg::ST_OFF;
        end else if (trig_hit) begin
          st_next = iotcm_pkg::ST_POST;
        end
      end
      iotcm_pkg::ST_POST: begin
        if (stop_cmd || post_full) begin
          st_next = iotcm_pkg::ST_OFF;
        end
      end
      default: begin
        st_next = iotcm_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= iotcm_pkg::ST_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Flags; a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_reg  <= 1'b0;
      ovf_reg   <= 1'b0;
      done_reg  <= 1'b0;
      ttime_reg <= 32'h0000_0000;
    end else begin
      trig_reg <= trig_set || (trig_reg && !start);
      ovf_reg  <= ovf_hit || (ovf_reg && !start);
      done_reg <= post_full || snap_req || (done_reg && !start);
      if (trig_set && !trig_reg) begin
        ttime_reg <= time_reg;
      end
    end
  end

  // ==========================================================
  // Timers; match time counts 10 ms ticks
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= 32'h0000_0000;
      time_reg     <= 32'h0000_0000;
      per_cnt_reg  <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
      time_reg     <= time_reg + (tick ? 32'h0000_0001 : 32'h0000_0000);
      if (start || per_fire) begin
        per_cnt_reg <= 16'h0000;
      end else if (tick) begin
        per_cnt_reg <= per_cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_tk_reg <= 16'h0000;
      run_tk_reg  <= 2'h0;
    end else begin
      if (cpu.scan_start) begin
        scan_tk_reg <= 16'h0000;
      end else if (tick && scan_tk_reg != 16'hFFFF) begin
        scan_tk_reg <= scan_tk_reg + 16'h0001;
      end
      // Two ticks while running prove more than one tick of run time
      if (!cpu_ok) begin
        run_tk_reg <= 2'h0;
      end else if (tick && run_tk_reg != 2'h2) begin
        run_tk_reg <= run_tk_reg + 2'h1;
      end
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg   <= iotcm_pkg::M_CONT_CHART;
      and_reg    <= 1'b0;
      period_reg <= `IOTCM_PERIOD_RST;
      npts_reg   <= `IOTCM_NPTS_RST;
      ptype_reg  <= 32'h0000_0000;
      ten_reg    <= 16'h0000;
      tword_reg  <= 16'h0000;
    end else if (bus.wr) begin
      if (a_ctrl) begin
        mode_reg <= iotcm_pkg::iotcm_mode_t'(bus.wdata[2:0]);
        and_reg  <= bus.wdata[`IOTCM_CTRL_AND];
      end else if (bus.addr == `IOTCM_A_PERIOD) begin
        period_reg <= (bus.wdata[15:0] == 16'h0000) ? `IOTCM_PERIOD_RST : bus.wdata[15:0];
      end else if (bus.addr == `IOTCM_A_NPTS) begin
        npts_reg <= (bus.wdata[4:0] == 5'h00) ? `IOTCM_NPTS_RST :
                    (32'(bus.wdata[4:0]) > NPT) ? 5'(NPT) : bus.wdata[4:0];
      end else if (bus.addr == `IOTCM_A_PTYPE) begin
        ptype_reg <= bus.wdata;
      end else if (bus.addr == `IOTCM_A_TCFG) begin
        ten_reg   <= bus.wdata[15:0];
        tword_reg <= bus.wdata[31:16];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tval_reg <= '0;
    end else if (bus.wr && a_tval) begin
      tval_reg[bus.addr[3:0]] <= bus.wdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      baddr_reg <= '0;
    end else if (bus.wr && bus.addr == `IOTCM_A_BADDR) begin
      baddr_reg <= bus.wdata[AW-1:0];
    end else if (bus.rd && a_bdata) begin
      baddr_reg <= baddr_reg + 1'b1;
    end
  end

  // ==========================================================
  // Register reads
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (a_ctrl) begin
      rd_mux = {28'h0000000, and_reg, mode_reg};
    end else if (bus.addr == `IOTCM_A_STATUS) begin
      rd_mux = {28'h0000000, done_reg, ovf_reg, trig_reg, active};
    end else if (bus.addr == `IOTCM_A_PERIOD) begin
      rd_mux = {16'h0000, period_reg};
    end else if (bus.addr == `IOTCM_A_NPTS) begin
      rd_mux = {27'h0000000, npts_reg};
    end else if (bus.addr == `IOTCM_A_PTYPE) begin
      rd_mux = ptype_reg;
    end else if (bus.addr == `IOTCM_A_TCFG) begin
      rd_mux = {tword_reg, ten_reg};
    end else if (bus.addr == `IOTCM_A_TTIME) begin
      rd_mux = ttime_reg;
    end else if (bus.addr == `IOTCM_A_WPTR) begin
      rd_mux = 32'(wptr_reg);
    end else if (bus.addr == `IOTCM_A_BADDR) begin
      rd_mux = 32'(baddr_reg);
    end else if (a_tval) begin
      rd_mux = {16'h0000, tval_reg[bus.addr[3:0]]};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus.rd) begin
      rdata_reg <= a_bdata ? {16'h0000, mem[baddr_reg]} : rd_mux;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign bus_rdata            = rdata_reg;
  assign pt_sel               = idx_reg;
  assign trigger_match_flag   = trig_reg;
  assign sampling_active_flag = active;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  post_end_a: assert property (post_full |=> st_reg == iotcm_pkg::ST_OFF)
    else $error("post-trigger capture did not end");
  post_cap_a: assert property (st_reg == iotcm_pkg::ST_POST |-> post_reg <= HALF_LIM)
    else $error("post-trigger count past half buffer");
  no_end_a: assert property ((st_reg == iotcm_pkg::ST_RUN && m_trig && !trig_hit &&
                             !stop_cmd) |=> st_reg == iotcm_pkg::ST_RUN)
    else $error("untriggered capture ended by itself");
  cmd_only_a: assert property ((m_cmd && go) |-> trace_sample_instruction)
    else $error("command trace stored without instruction");
  arm_run_a: assert property ((st_reg == iotcm_pkg::ST_OFF && m_cmd &&
                              trace_arm_instruction) |=> sampling_active_flag)
    else $error("arm did not start sampling");
  disarm_a: assert property ((st_reg == iotcm_pkg::ST_RUN && m_cmd &&
                             trace_disarm_instruction) |=> (!active && !go)[*2])
    else $error("disarm did not stop sampling");
  snap_once_a: assert property (snap_req |=> (!active && busy_reg) ##1 !go)
    else $error("snapshot did not store once and stop");
  halt_gate_a: assert property (!cpu_ok |-> !go)
    else $error("sample taken with cpu not running");
  overrun_a: assert property (ovf_hit |=> (!active && ovf_reg))
    else $error("overrun did not stop trace");
  trig_time_a: assert property ((trig_set && !trig_reg) |=>
                                (trigger_match_flag && ttime_reg == $past(time_reg)))
    else $error("match time not recorded");
endmodule : iotcm_top
`default_nettype wire

// ==== tb/iotcm_io_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module iotcm_io_model (
  input  wire logic [3:0]  pt_sel,
  output logic      [31:0] pt_data
);
  // Both halves differ per point, so a swapped or stale word shows up
  assign pt_data = {12'hC3A, pt_sel, 12'h5A5, ~pt_sel};
endmodule : iotcm_io_model
`default_nettype wire

// ==== tb/io_trace_capture_monitor_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module io_trace_capture_monitor_tb;
  logic                  ref_clk = 1'b0;
  logic                  reset_n = 1'b0;
  iotcm_pkg::iotcm_bus_t bus = '0;
  iotcm_pkg::iotcm_cpu_t cpu = '{iotcm_pkg::CS_RUN, iotcm_pkg::EX_FREE, 1'b0, 1'b0};
  logic [2:0]            ins = 3'h0;
  logic [15:0][15:0]     trig_io = '0;
  logic [31:0]           bus_rdata;
  logic [31:0]           pt_data;
  logic [3:0]            pt_sel;
  logic                  tmf;
  logic                  saf;
  logic [31:0]           rv;
  int                    n_fail = 0;
  int                    cmp_count = 0;

  always #2 ref_clk = ~ref_clk;

  // Short tick and buffer keep the triggered run near 3000 cycles
  iotcm_top #(.TICK_CYC(20), .NPT(16), .BUF_WORDS(256)) u_iotcm_top (
    .ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .bus_rdata(bus_rdata), .cpu(cpu),
    .trace_arm_instruction(ins[0]), .trace_sample_instruction(ins[1]),
    .trace_disarm_instruction(ins[2]), .pt_sel(pt_sel), .pt_data(pt_data),
    .trig_io(trig_io), .trigger_match_flag(tmf), .sampling_active_flag(saf));
  iotcm_io_model u_iotcm_io_model (.pt_sel(pt_sel), .pt_data(pt_data));

  // ==========================================
  // Access tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task rc(input string nm, input logic [4:0] a, input logic [31:0] exp);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 rv = bus_rdata;
    chk(nm, rv, exp);
    @(posedge ref_clk);
  endtask : rc
  task pulse(input logic [2:0] p);
    ins <= p;
    @(posedge ref_clk);
    ins <= 3'h0;
    repeat (4) @(posedge ref_clk);
  endtask : pulse
  task results;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // ==========================================
  // Sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rc("period", 5'h02, 32'h1);
    rc("npts", 5'h03, 32'h1);
    rc("status", 5'h01, 32'h0);
    wr(5'h0A, 32'hFFFF_FFFF);
    rc("unmapped", 5'h0A, 32'h0);
    $display("test reset done");
    wr(5'h03, 32'h2);
    wr(5'h04, 32'h8);
    wr(5'h00, 32'h4);
    pulse(3'h2);
    rc("wptr unarmed", 5'h07, 32'h0);
    pulse(3'h1);
    chk("active", {31'h0, saf}, 32'h1);
    cpu.state <= iotcm_pkg::CS_HALT_STATE;
    pulse(3'h2);
    cpu.state <= iotcm_pkg::CS_RUN;
    cpu.ochg_halt <= 1'b1;
    pulse(3'h2);
    cpu.ochg_halt <= 1'b0;
    rc("wptr gated", 5'h07, 32'h0);
    pulse(3'h2);
    rc("wptr set", 5'h07, 32'h3);
    chk("cmd match", {31'h0, tmf}, 32'h1);
    wr(5'h08, 32'h0);
    rc("bit word", 5'h09, 32'h1);
    rc("dword low", 5'h09, 32'h5A5E);
    rc("dword high", 5'h09, 32'hC3A1);
    pulse(3'h4);
    chk("disarmed", {31'h0, saf}, 32'h0);
    pulse(3'h2);
    rc("wptr disarmed", 5'h07, 32'h3);
    $display("test command trace done");
    wr(5'h03, 32'h1);
    wr(5'h04, 32'h1);
    wr(5'h05, 32'h1);
    wr(5'h10, 32'h1);
    wr(5'h00, 32'h13);
    repeat (200) @(posedge ref_clk);
    chk("no trig", {31'h0, tmf}, 32'h0);
    chk("running", {31'h0, saf}, 32'h1);
    trig_io[0] <= 16'h1;
    for (int i = 0; i < 8000 && saf; i++) @(posedge ref_clk);
    // A hung post capture counts once; the run still reaches the verdict
    if (saf) n_fail++;
    rc("status done", 5'h01, 32'hA);
    $display("test trigger or done");
    wr(5'h05, 32'h3);
    wr(5'h11, 32'h1);
    wr(5'h00, 32'h1B);
    repeat (200) @(posedge ref_clk);
    chk("and partial", {31'h0, tmf}, 32'h0);
    trig_io[1] <= 16'h1;
    repeat (60) @(posedge ref_clk);
    chk("and full", {31'h0, tmf}, 32'h1);
    wr(5'h00, 32'h23);
    chk("stopped", {31'h0, saf}, 32'h0);
    $display("test trigger and done");
    trig_io[1] <= 16'h0;
    wr(5'h00, 32'h1D);
    repeat (100) @(posedge ref_clk);
    chk("snap idle", {31'h0, tmf}, 32'h0);
    chk("snap polling", {31'h0, saf}, 32'h1);
    rc("snap no store", 5'h07, 32'h0);
    trig_io[1] <= 16'h1;
    repeat (40) @(posedge ref_clk);
    rc("snap status", 5'h01, 32'hA);
    rc("snap once", 5'h07, 32'h1);
    $display("test snapshot done");
    wr(5'h03, 32'h10);
    wr(5'h04, 32'hAAAA_AAAA);
    wr(5'h00, 32'h12);
    // A 32-word set cannot finish within one short tick
    repeat (60) @(posedge ref_clk);
    rc("overrun status", 5'h01, 32'h4);
    $display("test overrun done");
    results();
  end
endmodule : io_trace_capture_monitor_tb
`default_nettype wire
